// File: verilog/pcl_defines.svh
// Purpose: Constants of the port configuration word loader.
// Assumes: Word addresses are byte addresses of 16-bit store words.
// Notes: Offsets, field positions, reset values and the word count only.
`ifndef PCL_DEFINES_SVH
`define PCL_DEFINES_SVH

// ------------------------------------------------------------
// Store word addresses
// ------------------------------------------------------------
`define PCL_WA_NSR_P2 8'h54
`define PCL_WA_NSR_P3 8'h56
`define PCL_WA_LNK_P0 8'h58
`define PCL_WA_LNK_P1 8'h5a
`define PCL_WA_LNK_P2 8'h5c
`define PCL_WA_LNK_P3 8'h5e
`define PCL_WA_SLT_P0 8'h60
`define PCL_WA_SLT_P1 8'h62
`define PCL_NUM_WORDS 8

// ------------------------------------------------------------
// Field positions inside a word
// ------------------------------------------------------------
`define PCL_F_NSR 0
`define PCL_F_AUX_HI 3
`define PCL_F_AUX_LO 1
`define PCL_F_D1 4
`define PCL_F_D2 5
`define PCL_F_PME_HI 7
`define PCL_F_PME_LO 6
`define PCL_F_DATA_HI 15
`define PCL_F_DATA_LO 8
`define PCL_F_SIMPL 0
`define PCL_F_SCLK 1
`define PCL_F_DSI 2
`define PCL_F_LOW_PRIORITY_VC_COUNT 3
`define PCL_F_PNUM_HI 6
`define PCL_F_PNUM_LO 4
`define PCL_F_TCM_HI 15
`define PCL_F_TCM_LO 9

// ------------------------------------------------------------
// Word reset values
// ------------------------------------------------------------
`define PCL_RST_PM 16'h00ff
`define PCL_RST_LNK 16'h0004
`define PCL_RST_SLT_P0 16'hfe02
`define PCL_RST_SLT_P1 16'hfe12

// ------------------------------------------------------------
// Register map, byte offsets
// ------------------------------------------------------------
`define PCL_RA_CTRL 8'h00
`define PCL_RA_STAT 8'h04
`define PCL_RA_CNT 8'h08
`define PCL_RA_IMG_HI 3'h1
`define PCL_CTRL_EN 0
`define PCL_CTRL_CLR 1
`define PCL_CTRL_RST 1'b1

`endif

// File: verilog/pcl_pkg.sv
// Purpose: Types of the port configuration word loader.
// Assumes: Nothing beyond the defines header.
// Notes: Constants live in pcl_defines.svh.
package pcl_pkg;

   typedef logic [15:0] pcl_word_t;

   typedef enum logic [1:0] {
      PCL_ST_IDLE = 2'b00,
      PCL_ST_LOAD = 2'b01,
      PCL_ST_DONE = 2'b10
   } pcl_state_e;

endpackage

// File: verilog/pcl_word_reg.sv
// Purpose: One stored initialization word.
// Assumes: load is a one-cycle strobe.
// Notes: Holds its reset value until a word is loaded.
`timescale 1ns/10ps
module pcl_word_reg #(
   parameter logic [15:0] RESET_VAL = 16'h0000
) (
   input wire logic pclk, // Clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic load, // Take load_data this cycle.
   input wire pcl_pkg::pcl_word_t load_data, // Word from the store.
   output pcl_pkg::pcl_word_t q // Stored word.
);
   import pcl_pkg::*;

   pcl_word_t word_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_q <= RESET_VAL;
      end else if (load) begin
         word_q <= load_data;
      end
   end

   assign q = word_q;

endmodule

// File: verilog/pcl_apb_slave.sv
// Purpose: APB handshake with one wait state.
// Assumes: rd_data and acc_err are decoded from the held address.
// Notes: Read data and error are captured on the same edge that raises pready.
`timescale 1ns/10ps
module pcl_apb_slave (
   input wire logic pclk, // Clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic psel, // Slave select.
   input wire logic penable, // Access phase.
   input wire logic pwrite, // Write when high.
   input wire logic [31:0] rd_data, // Decoded read data.
   input wire logic acc_err, // Decoded access error.
   output logic pready, // Transfer completes.
   output logic [31:0] prdata, // Read data.
   output logic pslverr, // Error response.
   output logic wr_fire // Write takes effect this edge.
);
   import pcl_pkg::*;

   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic first_acc;

   assign first_acc = psel & penable & ~pready_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= first_acc;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (first_acc) begin
         prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
         pslverr_q <= acc_err;
      end else begin
         pslverr_q <= 1'b0;
      end
   end

   assign pready = pready_q;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;
   assign wr_fire = psel & penable & pready_q & pwrite & ~pslverr_q;

endmodule

// File: verilog/pcl_loader.sv
// Purpose: Loads 16-bit store words into per-port configuration fields.
// Assumes: The store presents one word per valid/ready handshake.
// Notes: Fields are read-only to software; APB shows word images.
//
// How it works
// R1: Word 54h/56h bit 0 sets no-soft-reset.
// R2: Bits 3:1 give aux current, ports 2, 3.
// R3: Bits 4, 5 give read-only D1, D2 support.
// R4: Bits 7:6 give D2/D1 wake-event support.
// R5: Bits 15:8 give read-only PM data byte.
// R6: Word 60h/62h bit 1 sets slot clock.
// R7: Bit 2 sets device-specific init required.
// R8: Bit 3 allocates VC1 as low-priority channel.
// R9: Bits 6:4 give logical port number.
// R10: Bits 15:9 map traffic classes onto VC0.
// R11: Word 62h bit 0 sets slot implemented.
// R12: Words 58h-5Eh load link-layer control words.
`timescale 1ns/10ps
`include "pcl_defines.svh"
module pcl_loader #(
   parameter int APB_AW = 12,
   parameter int CNT_W = 16
) (
   input wire logic pclk, // Clock, 10 MHz.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB access phase.
   input wire logic pwrite, // APB write.
   input wire logic [APB_AW-1:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic pready, // APB ready.
   output logic [31:0] prdata, // APB read data.
   output logic pslverr, // APB error.
   input wire logic cfg_valid, // Store word valid.
   input wire logic [7:0] cfg_addr, // Store word byte address.
   input wire pcl_pkg::pcl_word_t cfg_data, // Store word.
   input wire logic cfg_last, // Last word of the load.
   output logic cfg_ready, // Loader takes words.
   output logic load_done, // Last word was taken.
   output logic [1:0] no_soft_reset, // Ports 3, 2.
   output logic [5:0] aux_current, // Ports 3, 2, 3 bits each.
   output logic [1:0] d1_support, // Ports 3, 2.
   output logic [1:0] d2_support, // Ports 3, 2.
   output logic [3:0] wake_support, // Ports 3, 2; D2 high, D1 low.
   output logic [15:0] pm_data, // Ports 3, 2.
   output logic [63:0] link_layer_ctrl_word, // Ports 3 down to 0.
   output logic [1:0] slot_clock, // Ports 1, 0.
   output logic [1:0] dsi_required, // Ports 1, 0.
   output logic [1:0] low_priority_vc_count, // Ports 1, 0.
   output logic [5:0] port_number, // Ports 1, 0.
   output logic [13:0] tc_vc0_map, // Ports 1, 0; bits 7:1 each.
   output logic slot_implemented // Port 1.
);
   import pcl_pkg::*;

   // ------------------------------------------------------------
   // Parameter checks
   // ------------------------------------------------------------
   if (APB_AW < 9 || APB_AW > 32) begin : g_bad_aw
      $error("APB_AW must lie between 9 and 32");
   end
   if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
      $error("CNT_W must lie between 1 and 32");
   end
   if (`PCL_NUM_WORDS != 8) begin : g_bad_nw
      $error("The word table must hold exactly eight words");
   end

   localparam int NW = `PCL_NUM_WORDS;
   localparam int WI_NSR_P2 = 0;
   localparam int WI_NSR_P3 = 1;
   localparam int WI_LNK_P0 = 2;
   localparam int WI_LNK_P1 = 3;
   localparam int WI_LNK_P2 = 4;
   localparam int WI_LNK_P3 = 5;
   localparam int WI_SLT_P0 = 6;
   localparam int WI_SLT_P1 = 7;

   pcl_state_e state_q;
   pcl_state_e state_d;
   logic ctrl_en_q;
   logic [NW-1:0] loaded_q;
   logic stray_q;
   logic [CNT_W-1:0] cnt_q;
   logic cfg_ready_q;
   logic load_done_q;
   logic accept;
   logic [NW-1:0] word_hit;
   logic stray_hit;
   pcl_word_t word_img [NW];
   logic [31:0] rd_data;
   logic acc_err;
   logic wr_fire;
   logic [7:0] off;
   logic upper_ok;
   logic clr_req;
   logic wr_ctrl;

   // ------------------------------------------------------------
   // Store word decode
   // ------------------------------------------------------------
   assign accept = cfg_valid & cfg_ready_q;

   // Words outside this group set the stray flag and are not stored.
   always_comb begin
      word_hit = '0;
      stray_hit = 1'b0;
      if (cfg_addr == `PCL_WA_NSR_P2) begin
         word_hit[0] = 1'b1; // R1
      end else if (cfg_addr == `PCL_WA_NSR_P3) begin
         word_hit[1] = 1'b1; // R1
      end else if (cfg_addr == `PCL_WA_LNK_P0) begin
         word_hit[2] = 1'b1; // R12
      end else if (cfg_addr == `PCL_WA_LNK_P1) begin
         word_hit[3] = 1'b1; // R12
      end else if (cfg_addr == `PCL_WA_LNK_P2) begin
         word_hit[4] = 1'b1; // R12
      end else if (cfg_addr == `PCL_WA_LNK_P3) begin
         word_hit[5] = 1'b1; // R12
      end else if (cfg_addr == `PCL_WA_SLT_P0) begin
         word_hit[6] = 1'b1; // R6
      end else if (cfg_addr == `PCL_WA_SLT_P1) begin
         word_hit[7] = 1'b1; // R11
      end else begin
         stray_hit = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Word storage
   // ------------------------------------------------------------
   // Each word holds its power-up default until the store overwrites it.
   for (genvar i = 0; i < NW; i++) begin : g_word
      localparam logic [15:0] RST =
         (i < WI_LNK_P0) ? `PCL_RST_PM :
         (i < WI_SLT_P0) ? `PCL_RST_LNK :
         (i == WI_SLT_P0) ? `PCL_RST_SLT_P0 : `PCL_RST_SLT_P1;
      pcl_word_reg #(
         .RESET_VAL(RST)
      ) u_word (
         .pclk(pclk),
         .presetn(presetn),
         .load(accept & word_hit[i]),
         .load_data(cfg_data),
         .q(word_img[i])
      );
   end

   // ------------------------------------------------------------
   // Load sequence
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         PCL_ST_IDLE: begin
            if (ctrl_en_q) begin
               state_d = PCL_ST_LOAD;
            end
         end
         PCL_ST_LOAD: begin
            if (!ctrl_en_q) begin
               state_d = PCL_ST_IDLE;
            end else if (accept && cfg_last) begin
               state_d = PCL_ST_DONE;
            end
         end
         PCL_ST_DONE: begin
            if (!ctrl_en_q) begin
               state_d = PCL_ST_IDLE;
            end
         end
         default: begin
            state_d = PCL_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= PCL_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Ready follows the next state so no word is taken after the last.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ready_q <= 1'b0;
      end else begin
         cfg_ready_q <= (state_d == PCL_ST_LOAD);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_done_q <= 1'b0;
      end else begin
         load_done_q <= (state_d == PCL_ST_DONE);
      end
   end

   // ------------------------------------------------------------
   // Software control
   // ------------------------------------------------------------
   assign off = paddr[7:0];
   assign upper_ok = (paddr[APB_AW-1:8] == '0);
   assign wr_ctrl = wr_fire && upper_ok && (off == `PCL_RA_CTRL);
   assign clr_req = wr_ctrl && pwdata[`PCL_CTRL_CLR];

   // Clearing the enable parks the sequence in idle until it is set again.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_en_q <= `PCL_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_en_q <= pwdata[`PCL_CTRL_EN];
      end
   end

   // ------------------------------------------------------------
   // Load bookkeeping
   // ------------------------------------------------------------
   // A word taken in the clearing cycle still marks its flag.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loaded_q <= '0;
      end else begin
         loaded_q <= (loaded_q & {NW{~clr_req}}) |
                     (word_hit & {NW{accept}});
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stray_q <= 1'b0;
      end else begin
         stray_q <= (stray_q & ~clr_req) | (accept & stray_hit);
      end
   end

   // The count wraps; a word taken while clearing restarts it at one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else if (clr_req) begin
         cnt_q <= accept ? CNT_W'(1) : '0;
      end else if (accept) begin
         cnt_q <= cnt_q + CNT_W'(1);
      end
   end

   // ------------------------------------------------------------
   // Register read decode
   // ------------------------------------------------------------
   // Stored fields are read-only; writing them is an error.
   always_comb begin
      rd_data = 32'h0000_0000;
      acc_err = 1'b0;
      if (!upper_ok || off[1:0] != 2'b00) begin
         acc_err = 1'b1;
      end else if (off == `PCL_RA_CTRL) begin
         rd_data[`PCL_CTRL_EN] = ctrl_en_q;
      end else if (off == `PCL_RA_STAT) begin
         rd_data[NW-1:0] = loaded_q;
         rd_data[NW] = stray_q;
         rd_data[NW+2:NW+1] = state_q;
         acc_err = pwrite;
      end else if (off == `PCL_RA_CNT) begin
         rd_data[CNT_W-1:0] = cnt_q;
         acc_err = pwrite;
      end else if (off[7:5] == `PCL_RA_IMG_HI) begin
         rd_data[15:0] = word_img[off[4:2]]; // R3 R5
         acc_err = pwrite;
      end else begin
         acc_err = 1'b1;
      end
   end

   pcl_apb_slave u_apb (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .rd_data(rd_data),
      .acc_err(acc_err),
      .pready(pready),
      .prdata(prdata),
      .pslverr(pslverr),
      .wr_fire(wr_fire)
   );

   // ------------------------------------------------------------
   // Power-management fields of ports 2 and 3
   // ------------------------------------------------------------
   assign no_soft_reset = {word_img[WI_NSR_P3][`PCL_F_NSR],
                           word_img[WI_NSR_P2][`PCL_F_NSR]}; // R1
   assign aux_current =
      {word_img[WI_NSR_P3][`PCL_F_AUX_HI:`PCL_F_AUX_LO],
       word_img[WI_NSR_P2][`PCL_F_AUX_HI:`PCL_F_AUX_LO]}; // R2
   assign d1_support = {word_img[WI_NSR_P3][`PCL_F_D1],
                        word_img[WI_NSR_P2][`PCL_F_D1]}; // R3
   assign d2_support = {word_img[WI_NSR_P3][`PCL_F_D2],
                        word_img[WI_NSR_P2][`PCL_F_D2]}; // R3
   assign wake_support =
      {word_img[WI_NSR_P3][`PCL_F_PME_HI:`PCL_F_PME_LO],
       word_img[WI_NSR_P2][`PCL_F_PME_HI:`PCL_F_PME_LO]}; // R4
   assign pm_data =
      {word_img[WI_NSR_P3][`PCL_F_DATA_HI:`PCL_F_DATA_LO],
       word_img[WI_NSR_P2][`PCL_F_DATA_HI:`PCL_F_DATA_LO]}; // R5

   // ------------------------------------------------------------
   // Link-layer control words of ports 0 to 3
   // ------------------------------------------------------------
   assign link_layer_ctrl_word = {word_img[WI_LNK_P3],
                                  word_img[WI_LNK_P2],
                                  word_img[WI_LNK_P1],
                                  word_img[WI_LNK_P0]}; // R12

   // ------------------------------------------------------------
   // Slot and channel fields of ports 0 and 1
   // ------------------------------------------------------------
   assign slot_clock = {word_img[WI_SLT_P1][`PCL_F_SCLK],
                        word_img[WI_SLT_P0][`PCL_F_SCLK]}; // R6
   assign dsi_required = {word_img[WI_SLT_P1][`PCL_F_DSI],
                          word_img[WI_SLT_P0][`PCL_F_DSI]}; // R7
   assign low_priority_vc_count =
      {word_img[WI_SLT_P1][`PCL_F_LOW_PRIORITY_VC_COUNT],
       word_img[WI_SLT_P0][`PCL_F_LOW_PRIORITY_VC_COUNT]}; // R8
   assign port_number =
      {word_img[WI_SLT_P1][`PCL_F_PNUM_HI:`PCL_F_PNUM_LO],
       word_img[WI_SLT_P0][`PCL_F_PNUM_HI:`PCL_F_PNUM_LO]}; // R9
   assign tc_vc0_map =
      {word_img[WI_SLT_P1][`PCL_F_TCM_HI:`PCL_F_TCM_LO],
       word_img[WI_SLT_P0][`PCL_F_TCM_HI:`PCL_F_TCM_LO]}; // R10
   assign slot_implemented = word_img[WI_SLT_P1][`PCL_F_SIMPL]; // R11

   assign cfg_ready = cfg_ready_q;
   assign load_done = load_done_q;

endmodule

// File: test/pcl_loader_properties.sv
// Purpose: Port checks of the configuration word loader.
// Assumes: Bound to pcl_loader; one clock domain.
// Notes: Field checks look one edge after a word is taken.
`timescale 1ns/10ps
module pcl_loader_props #(
   parameter int APB_AW = 12,
   parameter int CNT_W = 16
) (
   input wire logic pclk, // Clock.
   input wire logic presetn, // Reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB access phase.
   input wire logic pready, // APB ready.
   input wire logic pslverr, // APB error.
   input wire logic cfg_valid, // Word valid.
   input wire logic [7:0] cfg_addr, // Word address.
   input wire pcl_pkg::pcl_word_t cfg_data, // Word.
   input wire logic cfg_last, // Last word.
   input wire logic cfg_ready, // Loader takes words.
   input wire logic load_done, // Load finished.
   input wire logic [1:0] no_soft_reset, // Ports 3, 2.
   input wire logic [5:0] aux_current, // Ports 3, 2.
   input wire logic [1:0] d1_support, // Ports 3, 2.
   input wire logic [1:0] d2_support, // Ports 3, 2.
   input wire logic [3:0] wake_support, // Ports 3, 2.
   input wire logic [15:0] pm_data, // Ports 3, 2.
   input wire logic [63:0] link_layer_ctrl_word, // Ports 3 to 0.
   input wire logic [1:0] slot_clock, // Ports 1, 0.
   input wire logic [1:0] dsi_required, // Ports 1, 0.
   input wire logic [1:0] low_priority_vc_count, // Ports 1, 0.
   input wire logic [5:0] port_number, // Ports 1, 0.
   input wire logic [13:0] tc_vc0_map, // Ports 1, 0.
   input wire logic slot_implemented // Port 1.
);
   import pcl_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic take = cfg_valid && cfg_ready;
   sequence s_setup; psel && !penable; endsequence
   sequence s_wait; psel && penable && !pready; endsequence
   a_apb_one_wait: assert property (s_setup ##1 s_wait |=> pready)
      else $error("pready late");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr alone");
   a_nsr_port2: assert property (
      take && cfg_addr == 8'h54 |=> no_soft_reset[0] == $past(cfg_data[0]))
      else $error("no soft reset wrong");
   a_aux_port3: assert property (
      take && cfg_addr == 8'h56 |=> aux_current[5:3] == $past(cfg_data[3:1]))
      else $error("aux current wrong");
   a_dstate_port2: assert property (
      take && cfg_addr == 8'h54 |=>
      {d2_support[0], d1_support[0]} == $past(cfg_data[5:4]))
      else $error("d1 d2 support wrong");
   a_wake_port3: assert property (
      take && cfg_addr == 8'h56 |=> wake_support[3:2] == $past(cfg_data[7:6]))
      else $error("wake support wrong");
   a_pmdata_port2: assert property (
      take && cfg_addr == 8'h54 |=> pm_data[7:0] == $past(cfg_data[15:8]))
      else $error("pm data wrong");
   a_link_port2: assert property (
      take && cfg_addr == 8'h5c |=>
      link_layer_ctrl_word[47:32] == $past(cfg_data))
      else $error("link word wrong");
   a_slot_port0: assert property (
      take && cfg_addr == 8'h60 |=> {low_priority_vc_count[0],
      dsi_required[0], slot_clock[0], port_number[2:0], tc_vc0_map[6:0]} ==
      {$past(cfg_data[3:1]), $past(cfg_data[6:4]), $past(cfg_data[15:9])})
      else $error("port 0 fields wrong");
   a_slot_port1: assert property (
      take && cfg_addr == 8'h62 |=> {low_priority_vc_count[1],
      dsi_required[1], slot_clock[1], port_number[5:3], tc_vc0_map[13:7],
      slot_implemented} == {$past(cfg_data[3:1]), $past(cfg_data[6:4]),
      $past(cfg_data[15:9]), $past(cfg_data[0])})
      else $error("port 1 fields wrong");
   a_done_last: assert property (take && cfg_last |=> load_done && !cfg_ready)
      else $error("load not done");
endmodule

// File: test/pcl_store_model.sv
// Purpose: Configuration store that hands words to the loader.
// Assumes: The bench queues words with push.
// Notes: Random stalls; lines change every idle cycle.
`timescale 1ns/10ps
module pcl_store_model (
   input wire logic pclk, // Clock.
   input wire logic presetn, // Reset, active low.
   input wire logic cfg_ready, // Loader takes words.
   output logic cfg_valid, // Word valid.
   output logic [7:0] cfg_addr, // Word address.
   output pcl_pkg::pcl_word_t cfg_data, // Word.
   output logic cfg_last // Last word.
);
   import pcl_pkg::*;
   logic [24:0] q[$];
   int unsigned stall = 0;
   task automatic push(input logic [7:0] a, input pcl_word_t d,
      input logic l);
      q.push_back({l, a, d});
   endtask
   // A word is held until the loader takes it.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_valid <= 1'b0;
         cfg_addr <= 8'h00;
         cfg_data <= 16'h0000;
         cfg_last <= 1'b0;
      end else if (!cfg_valid || cfg_ready) begin
         if (cfg_valid) stall = $urandom_range(2);
         if (q.size() != 0 && stall == 0) begin
            {cfg_last, cfg_addr, cfg_data} <= q.pop_front();
            cfg_valid <= 1'b1;
         end else begin
            if (stall != 0) stall--;
            cfg_valid <= 1'b0;
            cfg_addr <= ~cfg_addr;
            cfg_data <= ~cfg_data;
         end
      end
   end
endmodule

// File: test/tb.sv
// Purpose: Self-checking bench of the configuration word loader.
// Assumes: One wait state on APB, store model on the word side.
// Notes: Array w holds the expected word images.
`timescale 1ns/10ps
module tb;
   import pcl_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr, cfg_valid, cfg_last, cfg_ready, load_done;
   logic [7:0] cfg_addr;
   pcl_word_t cfg_data;
   logic [1:0] no_soft_reset, d1_support, d2_support, slot_clock;
   logic [1:0] dsi_required, low_priority_vc_count;
   logic [5:0] aux_current, port_number;
   logic [3:0] wake_support;
   logic [15:0] pm_data;
   logic [63:0] link_layer_ctrl_word;
   logic [13:0] tc_vc0_map;
   logic slot_implemented;
   int num_errors = 0, cmp_count = 0, cyc = 0;
   pcl_word_t w[8] = '{16'h00ff, 16'h00ff, 16'h0004, 16'h0004,
      16'h0004, 16'h0004, 16'hfe02, 16'hfe12};
   always #50 pclk = ~pclk;
   pcl_loader #(.APB_AW(12), .CNT_W(16)) DUT (.*);
   pcl_store_model store (.*);
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         num_errors++;
         print_verdict();
      end
   end
   task automatic check(input string n, input logic [63:0] e,
      input logic [63:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, input logic [31:0] e, input logic ee);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      check("pslverr", ee, pslverr);
      if (!wr) check("prdata", e, prdata);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wait_done();
      int n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (load_done !== 1'b1 && n < 100);
      check("load_done", 1, load_done);
      @(posedge pclk);
   endtask
   task automatic check_fields();
      check("nsr", {w[1][0], w[0][0]}, no_soft_reset);
      check("aux", {w[1][3:1], w[0][3:1]}, aux_current);
      check("d1", {w[1][4], w[0][4]}, d1_support);
      check("d2", {w[1][5], w[0][5]}, d2_support);
      check("wake", {w[1][7:6], w[0][7:6]}, wake_support);
      check("pmd", {w[1][15:8], w[0][15:8]}, pm_data);
      check("sclk", {w[7][1], w[6][1]}, slot_clock);
      check("dsi", {w[7][2], w[6][2]}, dsi_required);
      check("low_priority_vc_count", {w[7][3], w[6][3]}, low_priority_vc_count);
      check("pnum", {w[7][6:4], w[6][6:4]}, port_number);
      check("tcm", {w[7][15:9], w[6][15:9]}, tc_vc0_map);
      check("simpl", w[7][0], slot_implemented);
      check("llc", {w[5], w[4], w[3], w[2]}, link_layer_ctrl_word);
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      pcl_word_t d;
      void'($urandom(58));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      check_fields();
      apb(0, 12'h000, 0, 32'h1, 0);
      apb(0, 12'h004, 0, 32'h200, 0);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         d = $urandom;
         w[i] = d;
         store.push(8'h54 + 8'(2 * i), d, i == 7);
      end
      wait_done();
      check_fields();
      apb(0, 12'h004, 0, 32'h4ff, 0);
      apb(0, 12'h008, 0, 32'h8, 0);
      for (int i = 0; i < 8; i++) apb(0, 12'h020 + 12'(4 * i), 0, w[i], 0);
      $display("test full load done");
      apb(1, 12'h000, 32'h0, 0, 0);
      apb(0, 12'h004, 0, 32'h0ff, 0);
      store.push(8'h64, 16'h1234, 0);
      store.push(8'h54, 16'hffff, 0);
      store.push(8'h54, 16'h0000, 0);
      store.push(8'h62, 16'hffff, 1);
      w[0] = 16'h0000;
      w[7] = 16'hffff;
      apb(1, 12'h000, 32'h3, 0, 0);
      apb(0, 12'h000, 0, 32'h1, 0);
      wait_done();
      check_fields();
      apb(0, 12'h008, 0, 32'h4, 0);
      $display("test reload done");
      apb(0, 12'h00c, 0, 0, 1);
      apb(0, 12'h002, 0, 0, 1);
      apb(0, 12'h104, 0, 0, 1);
      apb(1, 12'h004, 32'h0, 0, 1);
      apb(0, 12'h004, 0, 32'h581, 0);
      $display("test refusals done");
      print_verdict();
   end
endmodule
bind pcl_loader pcl_loader_props #(.APB_AW(APB_AW), .CNT_W(CNT_W))
   u_props (.*);
